// ===== core/kfc_consts.svh
// Constants for the keypad and fan command handler
// Notes on behaviour
// - After reset every key event is reported
// - Command 0x17 sets press and release masks
// - Key masks saved with the boot state
// - Answer type is command type OR 0x40 unless the command is refused
// - Command 0x18 answers held, pressed, released masks
// - Pressed and released masks gather since last poll
// - Poll shows all keys regardless of masks
// - Command 0x19 sets fail-safe mask and timeout
// - Timeout expiry forces fail-safe fans to full
// - Fan PWM repeats at about eighteen hertz
// - Tach ignored for delay counts after turn-on
// - Glitch delay defaults to one count
// - Command 0x1A sets four glitch delays
// - Glitch delays saved with the boot state
// - Command 0x1B answers four powers and mask
// - Fan powers range zero to one hundred
`ifndef KFC_CONSTS_SVH
`define KFC_CONSTS_SVH
`define KEY_UP_BIT      6'h01
`define KEY_ACCEPT_BIT  6'h02
`define KEY_ABORT_BIT   6'h04
`define KEY_WEST_BIT    6'h08
`define KEY_EAST_BIT    6'h10
`define KEY_SOUTH_BIT   6'h20
`define KEY_MASK_RST    (`KEY_UP_BIT | `KEY_ACCEPT_BIT | `KEY_ABORT_BIT | `KEY_WEST_BIT | `KEY_EAST_BIT | `KEY_SOUTH_BIT)
`define CMD_STORE_BOOT  8'h04
`define CMD_FAN_POWER   8'h11
`define CMD_KEY_MASKS   8'h17
`define CMD_KEY_POLL    8'h18
`define CMD_FAILSAFE    8'h19
`define CMD_GLITCH      8'h1a
`define CMD_FAN_QUERY   8'h1b
`define RSP_FLAG        8'h40
`define LEN_POLL        4'h3
`define LEN_QUERY       4'h5
`define OFS_CMD         8'h00
`define OFS_ARG         8'h04
`define OFS_RSP         8'h08
`define OFS_RSP_D       8'h0c
`define OFS_RSP_E       8'h10
`define OFS_EVT         8'h14
`define OFS_BOOT_KEYS   8'h18
`define OFS_BOOT_GD     8'h1c
`define OFS_STATUS      8'h20
`define POWER_FULL      8'h64
`define POWER_RST       8'h00
`define GLITCH_RST      8'h01
`define PWM_LAST_STEP   7'h63
`define CLK_NS          100
`define TICK_NS         552500
`define EIGHTH_NS       125000000
`endif

// ===== core/kfc_pkg.sv
// Types shared by the keypad and fan command handler
package kfc_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_EXEC = 2'h2} cmd_state_t;
  typedef logic [5:0] keys_t;
  typedef logic [7:0] byte_t;
endpackage

// ===== core/kfc_ifs.sv
// Interfaces between the handler and its fan and key sub-blocks
`timescale 1ns/1ps
interface fan_if;
  logic [6:0] phase;       // PWM step 0..99
  logic       tick;        // One pulse per step
  logic [7:0] power;       // Effective power 0..100
  logic [7:0] delay;       // Tach blanking counts
  logic       pwm;         // Fan drive
  logic       tach_pulse;  // Accepted tach edge
  modport ctl (output phase, tick, power, delay, input pwm, tach_pulse);
  modport ch (input phase, tick, power, delay, output pwm, tach_pulse);
endinterface // fan_if

interface key_if;
  import kfc_pkg::*;
  logic  poll;      // Clear accumulators
  keys_t held;      // Keys down now
  keys_t pressed;   // Pressed since poll
  keys_t released;  // Released since poll
  keys_t press_evt; // One-cycle press events
  keys_t rel_evt;   // One-cycle release events
  modport ctl (output poll, input held, pressed, released, press_evt, rel_evt);
  modport trk (input poll, output held, pressed, released, press_evt, rel_evt);
endinterface // key_if

// ===== core/fan_channel.sv
// One fan: PWM drive and tachometer blanking after turn-on
`timescale 1ns/1ps
module fan_channel (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic tach_in,
  fan_if.ch         fif
);
  import kfc_pkg::*;
  logic       pwm_r;      // Drive level
  logic       pwm_nxt;    // Drive for next step
  logic [7:0] blank_r;    // Counts left to ignore
  logic       tach_d_r;   // Previous tach level
  logic       pulse_r;    // Accepted tach edge

  assign pwm_nxt = ({1'b0, fif.phase} < fif.power);
  assign fif.pwm = pwm_r;
  assign fif.tach_pulse = pulse_r;

  // Drive high while the step is below power
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_nxt;
    end
  end

  // Blanking restarts on each turn-on; the first count may be partial
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      blank_r <= 8'h00;
    end else if (pwm_nxt && !pwm_r) begin
      blank_r <= fif.delay;
    end else if (fif.tick && blank_r != 8'h00) begin
      blank_r <= blank_r - 8'h01;
    end
  end

  // Rising tach edges count only while powered and unblanked
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tach_d_r <= 1'b0;
      pulse_r  <= 1'b0;
    end else begin
      tach_d_r <= tach_in;
      pulse_r  <= tach_in && !tach_d_r && pwm_r && blank_r == 8'h00;
    end
  end

  property p_blank;
    @(posedge clk_sys) disable iff (!rstn)
    pulse_r |-> $past(blank_r) == 8'h00 && $past(pwm_r);
  endproperty
  a_blank: assert property (p_blank) else $error("tach edge accepted while blanked");
endmodule // fan_channel

// ===== core/key_tracker.sv
// Key state, edge events and since-poll accumulators
`timescale 1ns/1ps
module key_tracker (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [5:0] key_raw,
  key_if.trk              kif
);
  import kfc_pkg::*;
  keys_t held_r;     // Keys down
  keys_t press_r;    // Pressed since poll
  keys_t rel_r;      // Released since poll
  keys_t pev_r;      // Press event pulse
  keys_t rev_r;      // Release event pulse
  keys_t new_press;  // Fresh press edges
  keys_t new_rel;    // Fresh release edges

  assign new_press = key_raw & ~held_r;
  assign new_rel   = ~key_raw & held_r;
  assign kif.held = held_r;
  assign kif.pressed = press_r;
  assign kif.released = rel_r;
  assign kif.press_evt = pev_r;
  assign kif.rel_evt = rev_r;

  // Edges of every key, unmasked
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      held_r <= 6'h00;
      pev_r  <= 6'h00;
      rev_r  <= 6'h00;
    end else begin
      held_r <= key_raw;
      pev_r  <= new_press;
      rev_r  <= new_rel;
    end
  end

  // Poll clears, but an edge in the same cycle survives
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      press_r <= 6'h00;
      rel_r   <= 6'h00;
    end else begin
      press_r <= (kif.poll ? 6'h00 : press_r) | new_press;
      rel_r   <= (kif.poll ? 6'h00 : rel_r) | new_rel;
    end
  end
endmodule // key_tracker

// ===== core/keypad_fan_command_handler.sv
// Keypad and fan command handler with an APB register front end
`timescale 1ns/1ps
`include "kfc_consts.svh"
module keypad_fan_command_handler #(
  parameter int unsigned TICK_CYC   = `TICK_NS / `CLK_NS,
  parameter int unsigned EIGHTH_CYC = `EIGHTH_NS / `CLK_NS
) (
  input  wire logic           clk_sys,
  input  wire logic           rstn,
  input  wire logic [7:0]     paddr,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire kfc_pkg::keys_t key_raw,
  input  wire logic [3:0]     tach_in,
  output logic [3:0]          fan_pwm,
  output logic [3:0]          tach_pulse,
  output logic                key_report,
  output logic [3:0]          failsafe_active
);
  import kfc_pkg::*;

  // Bus side
  logic [31:0] prdata_r;      // Read data, loaded in setup
  logic        pready_r;      // High in the access phase
  logic        pslverr_r;     // Unmapped address
  logic [31:0] rd_mux;        // Selected register
  logic        hit;           // Address is mapped
  logic        wr_acc;        // Write completes
  logic        rd_acc;        // Read completes
  // Command engine
  cmd_state_t  state_r;       // Idle or executing
  logic [7:0]  cmd_r;         // Command type
  logic [31:0] arg_r;         // Data bytes 0..3
  logic        cmd_ok;        // Known and valid
  logic        exec;          // Execute this cycle
  logic        go_store, go_pow, go_keys, go_poll, go_fs, go_gd, go_query;
  logic [7:0]  rsp_type_r;    // Answer type
  logic [3:0]  rsp_len_r;     // Answer length
  logic        rsp_err_r;     // Command refused
  logic [39:0] rsp_data_r;    // Answer bytes 0..4
  // Settings
  keys_t       press_mask_r;  // Press report mask
  keys_t       rel_mask_r;    // Release report mask
  keys_t       boot_press_r;  // Saved press mask
  keys_t       boot_rel_r;    // Saved release mask
  logic [7:0]  power_r [4];   // Host fan power
  logic [7:0]  delay_r [4];   // Glitch delays
  logic [7:0]  boot_gd_r [4]; // Saved glitch delays
  // Fail-safe
  logic [3:0]  fs_mask_r;     // Fans under fail-safe
  logic [7:0]  fs_timeout_r;  // Reload, eighth seconds
  logic [7:0]  fs_cnt_r;      // Remaining eighths
  logic        fs_fired_r;    // Timeout ran out
  logic [3:0]  forced_r;      // Fans forced to full
  // Key events
  keys_t       evt_press_r, evt_rel_r;
  keys_t       evt_press_nxt, evt_rel_nxt;
  logic        key_report_r;  // Unread event pending
  logic        seen_keys_r;   // Masks ever written
  // Timebase
  logic [23:0] tick_div_r;    // Step prescaler
  logic        tick_r;        // 1/100 PWM period
  logic [6:0]  phase_r;       // PWM step
  logic [23:0] eighth_div_r;  // Eighth prescaler
  logic        eighth_r;      // 1/8 second pulse

  fan_if fif [4] ();
  key_if kif ();

  // Byte i of a data word
  function automatic byte_t byte_of(input logic [31:0] w, input logic [1:0] idx);
    return w[{idx, 3'b000} +: 8];
  endfunction

  // Power seen by a fan, full when forced
  function automatic byte_t eff_pow(input byte_t p, input logic force_full);
    return force_full ? `POWER_FULL : p;
  endfunction

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign key_report = key_report_r;
  assign failsafe_active = forced_r;
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign rd_acc = psel && penable && pready_r && !pwrite;

  // Register read map; misaligned and unknown addresses miss
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_CMD:       rd_mux = {24'h00_0000, cmd_r};
      `OFS_ARG:       rd_mux = arg_r;
      `OFS_RSP:       rd_mux = {15'h0000, rsp_err_r, 4'h0, rsp_len_r, rsp_type_r};
      `OFS_RSP_D:     rd_mux = rsp_data_r[31:0];
      `OFS_RSP_E:     rd_mux = {24'h00_0000, rsp_data_r[39:32]};
      `OFS_EVT:       rd_mux = {18'h0_0000, evt_rel_r, 2'h0, evt_press_r};
      `OFS_BOOT_KEYS: rd_mux = {18'h0_0000, boot_rel_r, 2'h0, boot_press_r};
      `OFS_BOOT_GD:   rd_mux = {boot_gd_r[3], boot_gd_r[2], boot_gd_r[1], boot_gd_r[0]};
      `OFS_STATUS:    rd_mux = {15'h0000, state_r == ST_EXEC, fs_cnt_r, 3'h0, fs_fired_r,
                                fs_mask_r};
      default:        hit = 1'b0;
    endcase
  end

  // One wait-free access: data and error are ready when penable rises
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= !hit;
      end
    end
  end

  // Argument word written by software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arg_r <= 32'h0000_0000;
    end else if (wr_acc && paddr == `OFS_ARG) begin
      arg_r <= pwdata;
    end
  end

  // Command FSM: a write to the command word runs one cycle later
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cmd_r   <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr_acc && paddr == `OFS_CMD) begin
            cmd_r   <= pwdata[7:0];
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Known commands and their argument checks
  always_comb begin
    cmd_ok = 1'b1;
    case (cmd_r)
      `CMD_FAN_POWER: begin
        for (int i = 0; i < 4; i++) begin
          if (byte_of(arg_r, 2'(i)) > `POWER_FULL) cmd_ok = 1'b0;
        end
      end
      `CMD_FAILSAFE: cmd_ok = byte_of(arg_r, 2'd1) != 8'h00;
      `CMD_STORE_BOOT, `CMD_KEY_MASKS, `CMD_KEY_POLL, `CMD_GLITCH, `CMD_FAN_QUERY:
        cmd_ok = 1'b1;
      default: cmd_ok = 1'b0;
    endcase
  end

  assign exec     = state_r == ST_EXEC;
  assign go_store = exec && cmd_ok && cmd_r == `CMD_STORE_BOOT;
  assign go_pow   = exec && cmd_ok && cmd_r == `CMD_FAN_POWER;
  assign go_keys  = exec && cmd_ok && cmd_r == `CMD_KEY_MASKS;
  assign go_poll  = exec && cmd_ok && cmd_r == `CMD_KEY_POLL;
  assign go_fs    = exec && cmd_ok && cmd_r == `CMD_FAILSAFE;
  assign go_gd    = exec && cmd_ok && cmd_r == `CMD_GLITCH;
  assign go_query = exec && cmd_ok && cmd_r == `CMD_FAN_QUERY;
  assign kif.poll = go_poll;

  // Answer packet; refused commands echo the type with the error bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_type_r <= 8'h00;
      rsp_len_r  <= 4'h0;
      rsp_err_r  <= 1'b0;
      rsp_data_r <= 40'h00_0000_0000;
    end else if (exec) begin
      rsp_type_r <= cmd_ok ? (cmd_r | `RSP_FLAG) : cmd_r;
      rsp_err_r  <= !cmd_ok;
      rsp_len_r  <= 4'h0;
      rsp_data_r <= 40'h00_0000_0000;
      if (go_poll) begin
        rsp_len_r  <= `LEN_POLL;
        rsp_data_r <= {16'h0000, 2'h0, kif.released, 2'h0, kif.pressed, 2'h0, kif.held};
      end
      if (go_query) begin
        rsp_len_r <= `LEN_QUERY;
        for (int i = 0; i < 4; i++) begin
          rsp_data_r[8*i +: 8] <= eff_pow(power_r[i], fs_fired_r && fs_mask_r[i]);
        end
        rsp_data_r[39:32] <= {4'h0, fs_mask_r};
      end
    end
  end

  // Report masks; all keys enabled out of reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      press_mask_r <= `KEY_MASK_RST;
      rel_mask_r   <= `KEY_MASK_RST;
      seen_keys_r  <= 1'b0;
    end else if (go_keys) begin
      press_mask_r <= arg_r[5:0];
      rel_mask_r   <= arg_r[13:8];
      seen_keys_r  <= 1'b1;
    end
  end

  // Host fan power
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) power_r[i] <= `POWER_RST;
    end else if (go_pow) begin
      for (int i = 0; i < 4; i++) power_r[i] <= byte_of(arg_r, 2'(i));
    end
  end

  // Glitch delays, byte 0 for fan 1
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) delay_r[i] <= `GLITCH_RST;
    end else if (go_gd) begin
      for (int i = 0; i < 4; i++) delay_r[i] <= byte_of(arg_r, 2'(i));
    end
  end

  // Boot copy; restoring it from storage is outside this block
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot_press_r <= `KEY_MASK_RST;
      boot_rel_r   <= `KEY_MASK_RST;
      for (int i = 0; i < 4; i++) boot_gd_r[i] <= `GLITCH_RST;
    end else if (go_store) begin
      boot_press_r <= press_mask_r;
      boot_rel_r   <= rel_mask_r;
      for (int i = 0; i < 4; i++) boot_gd_r[i] <= delay_r[i];
    end
  end

  // Fail-safe countdown; any power update restarts it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fs_mask_r    <= 4'h0;
      fs_timeout_r <= 8'h00;
      fs_cnt_r     <= 8'h00;
      fs_fired_r   <= 1'b0;
    end else if (go_fs) begin
      fs_mask_r    <= arg_r[3:0];
      fs_timeout_r <= arg_r[15:8];
      fs_cnt_r     <= arg_r[15:8];
      fs_fired_r   <= 1'b0;
    end else if (go_pow) begin
      fs_cnt_r   <= fs_timeout_r;
      fs_fired_r <= 1'b0;
    end else if (eighth_r && fs_cnt_r != 8'h00) begin
      fs_cnt_r <= fs_cnt_r - 8'h01;
      if (fs_cnt_r == 8'h01) fs_fired_r <= 1'b1;
    end
  end

  // Forced-fan indicator, one cycle behind the forced power
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      forced_r <= 4'h0;
    end else begin
      forced_r <= fs_mask_r & {4{fs_fired_r}};
    end
  end

  // Reading clears only the bits returned, so a new event is kept
  always_comb begin
    evt_press_nxt = evt_press_r | (kif.press_evt & press_mask_r);
    evt_rel_nxt   = evt_rel_r | (kif.rel_evt & rel_mask_r);
    if (rd_acc && paddr == `OFS_EVT) begin
      evt_press_nxt = (evt_press_r & ~prdata_r[5:0]) | (kif.press_evt & press_mask_r);
      evt_rel_nxt   = (evt_rel_r & ~prdata_r[13:8]) | (kif.rel_evt & rel_mask_r);
    end
  end

  // Pending key events
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_press_r  <= 6'h00;
      evt_rel_r    <= 6'h00;
      key_report_r <= 1'b0;
    end else begin
      evt_press_r  <= evt_press_nxt;
      evt_rel_r    <= evt_rel_nxt;
      key_report_r <= |{evt_press_nxt, evt_rel_nxt};
    end
  end

  // PWM step timebase, 100 steps per period
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_div_r <= 24'h00_0000;
      tick_r     <= 1'b0;
      phase_r    <= 7'h00;
    end else begin
      tick_r <= tick_div_r == 24'(TICK_CYC - 1);
      if (tick_div_r == 24'(TICK_CYC - 1)) begin
        tick_div_r <= 24'h00_0000;
        phase_r    <= (phase_r == `PWM_LAST_STEP) ? 7'h00 : phase_r + 7'h01;
      end else begin
        tick_div_r <= tick_div_r + 24'h00_0001;
      end
    end
  end

  // Eighth-second timebase for the fail-safe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      eighth_div_r <= 24'h00_0000;
      eighth_r     <= 1'b0;
    end else begin
      eighth_r <= eighth_div_r == 24'(EIGHTH_CYC - 1);
      if (eighth_div_r == 24'(EIGHTH_CYC - 1)) eighth_div_r <= 24'h00_0000;
      else eighth_div_r <= eighth_div_r + 24'h00_0001;
    end
  end

  // Fan channels
  for (genvar i = 0; i < 4; i++) begin : g_fan
    assign fif[i].phase = phase_r;
    assign fif[i].tick  = tick_r;
    assign fif[i].power = eff_pow(power_r[i], fs_fired_r && fs_mask_r[i]);
    assign fif[i].delay = delay_r[i];
    assign fan_pwm[i]    = fif[i].pwm;
    assign tach_pulse[i] = fif[i].tach_pulse;
    fan_channel u_fan (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tach_in (tach_in[i]),
      .fif     (fif[i])
    );
  end

  key_tracker u_keys (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .key_raw (key_raw),
    .kif     (kif)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_mask_rst;
    !seen_keys_r |-> press_mask_r == `KEY_MASK_RST && rel_mask_r == `KEY_MASK_RST;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("masks left reset value");
  property p_mask_evt;
    ##1 (evt_press_r & ~$past(evt_press_r) & ~$past(press_mask_r)) == 6'h00;
  endproperty
  a_mask_evt: assert property (p_mask_evt) else $error("masked press reported");
  property p_boot;
    go_store |=> boot_press_r == $past(press_mask_r) && boot_rel_r == $past(rel_mask_r);
  endproperty
  a_boot: assert property (p_boot) else $error("key masks not saved");
  property p_rsp;
    exec && cmd_ok |=> rsp_type_r == ($past(cmd_r) | `RSP_FLAG) && !rsp_err_r;
  endproperty
  a_rsp: assert property (p_rsp) else $error("answer type wrong");
  property p_poll;
    go_poll |=> rsp_len_r == `LEN_POLL && rsp_data_r[5:0] == $past(kif.held)
                && rsp_data_r[13:8] == $past(kif.pressed);
  endproperty
  a_poll: assert property (p_poll) else $error("poll answer wrong");
  property p_accum;
    go_poll |=> kif.pressed == kif.press_evt && kif.released == kif.rel_evt;
  endproperty
  a_accum: assert property (p_accum) else $error("accumulator not cleared");
  property p_forced;
    fs_fired_r && fs_mask_r[0] |-> fif[0].power == `POWER_FULL ##1 forced_r[0];
  endproperty
  a_forced: assert property (p_forced) else $error("fan not forced full");
  property p_restart;
    go_pow |=> fs_cnt_r == fs_timeout_r && !fs_fired_r;
  endproperty
  a_restart: assert property (p_restart) else $error("timeout not restarted");
  property p_fs_load;
    go_fs |=> fs_cnt_r == $past(arg_r[15:8]) && fs_mask_r == $past(arg_r[3:0]);
  endproperty
  a_fs_load: assert property (p_fs_load) else $error("fail-safe not loaded");
  property p_gd;
    go_gd |=> delay_r[0] == $past(arg_r[7:0]) && delay_r[3] == $past(arg_r[31:24]);
  endproperty
  a_gd: assert property (p_gd) else $error("glitch delays wrong");
  property p_query;
    go_query |=> rsp_len_r == `LEN_QUERY && rsp_data_r[35:32] == $past(fs_mask_r);
  endproperty
  a_query: assert property (p_query) else $error("fan query wrong");
endmodule // keypad_fan_command_handler

// ===== tb/host_apb.sv
// Host model: APB master that carries command packets into the handler
`timescale 1ns/1ps
module host_apb (
  input  wire logic        clk_sys,
  output logic [7:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int n_late = 0;  // Transfers that never saw pready

  // Bus idle from time zero
  initial begin
    paddr <= 8'h00;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h0;
  end

  // One transfer: setup, then access until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    // Read before this edge's updates land, so pready is the access value
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_late++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // host_apb

// ===== tb/test_keypad_fan_command_handler.sv
// Bench for the keypad and fan command handler
`timescale 1ns/1ps
module test_keypad_fan_command_handler;
  import kfc_pkg::*;
  logic clk_sys = 1'b0;  // 10 MHz system clock
  logic rstn;            // Active-low reset
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, key_report;
  logic [31:0] pwdata, prdata, q;
  keys_t key_raw;
  logic [3:0] tach_in, fan_pwm, tach_pulse, failsafe_active;
  int n_mismatch = 0, n_checks = 0, n;

  always #50 clk_sys = ~clk_sys;

  host_apb h (.clk_sys(clk_sys), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Short tick and eighth so fail-safe and PWM fit the run
  keypad_fan_command_handler #(.TICK_CYC(4), .EIGHTH_CYC(20)) i_dut (.clk_sys(clk_sys),
    .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_raw(key_raw), .tach_in(tach_in), .fan_pwm(fan_pwm), .tach_pulse(tach_pulse),
    .key_report(key_report), .failsafe_active(failsafe_active));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    h.xfer(1'b0, a, 32'h0, d, e);
    chk(what, exp, d);
  endtask

  // Argument first, then type, then the answer word
  task automatic cmd(input logic [7:0] t, input logic [31:0] a, input logic [31:0] exp);
    logic e;
    h.xfer(1'b1, 8'h04, a, q, e);
    h.xfer(1'b1, 8'h00, {24'h0, t}, q, e);
    rd(8'h08, "answer", exp);
  endtask

  task automatic complete_run();
    n_mismatch += h.n_late;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A bus wait that ran out ends the run
  always @(posedge clk_sys) if (h.n_late != 0) complete_run();

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic e;
    rstn <= 1'b0;
    key_raw <= 6'h00;
    tach_in <= 4'h0;  // Tach idle until the blanking test
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    cmd(8'h04, 32'h0, 32'h44);
    rd(8'h18, "boot keys", 32'h3f3f);
    rd(8'h1c, "boot delays", 32'h01010101);
    cmd(8'h17, 32'h0001, 32'h57);
    key_raw <= 6'h03;
    repeat (4) @(posedge clk_sys);
    chk("key report", 1, key_report);
    rd(8'h14, "events", 32'h01);
    cmd(8'h17, 32'h0, 32'h57);
    key_raw <= 6'h08;
    repeat (4) @(posedge clk_sys);
    cmd(8'h18, 32'h0, 32'h358);
    rd(8'h0c, "poll", 32'h030b08);
    cmd(8'h18, 32'h0, 32'h358);
    rd(8'h0c, "poll", 32'h08);
    cmd(8'h11, 32'h281e140a, 32'h51);
    cmd(8'h19, 32'h0205, 32'h59);
    cmd(8'h1b, 32'h0, 32'h55b);
    rd(8'h0c, "powers", 32'h281e140a);
    rd(8'h10, "fail-safe mask", 32'h05);
    repeat (80) @(posedge clk_sys);
    chk("forced fans", 4'h5, failsafe_active);
    cmd(8'h1b, 32'h0, 32'h55b);
    rd(8'h0c, "powers", 32'h28641464);
    cmd(8'h11, 32'h281e140a, 32'h51);
    chk("forced fans", 4'h0, failsafe_active);
    n = 0;
    // One PWM period of 100 steps of 4 cycles
    repeat (400) begin
      @(posedge clk_sys);
      if (fan_pwm[1] === 1'b1) n++;
    end
    chk("fan2 duty", 80, n);
    cmd(8'h19, 32'h0005, 32'h10019);
    cmd(8'h1a, 32'h04030201, 32'h5a);
    cmd(8'h04, 32'h0, 32'h44);
    rd(8'h1c, "boot delays", 32'h04030201);
    // Fan 2 turn-on: a tach edge inside two blanking steps is dropped
    n = 0;
    while (fan_pwm[1] !== 1'b0 && n < 800) begin
      @(posedge clk_sys);
      n++;
    end
    while (fan_pwm[1] !== 1'b1 && n < 800) begin
      @(posedge clk_sys);
      n++;
    end
    chk("fan2 turn-on", 1, fan_pwm[1]);
    tach_in <= 4'h2;
    n = 0;
    repeat (10) begin
      @(posedge clk_sys);
      if (tach_pulse[1] === 1'b1) n++;
    end
    chk("blanked tach", 0, n);
    tach_in <= 4'h0;
    @(posedge clk_sys);
    // Blanking over, drive still on: this edge counts once
    tach_in <= 4'h2;
    n = 0;
    repeat (10) begin
      @(posedge clk_sys);
      if (tach_pulse[1] === 1'b1) n++;
    end
    chk("tach pulse", 1, n);
    tach_in <= 4'h0;
    h.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped error", 1, e);
    complete_run();
  end
endmodule // test_keypad_fan_command_handler
